// >>> core/cmp_isqrt.sv
// Serial integer square root, one result bit per clock
`timescale 1ns/10ps
module cmp_isqrt #(
  parameter int OW = 32
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic [2*OW-1:0]   rad,
  output logic                   done,
  output logic      [OW-1:0]     root
);
  localparam int CW = $clog2(OW + 1);

  logic [2*OW-1:0] rad_q;
  logic [OW+1:0]   rem_q;
  logic [OW+1:0]   sh;
  logic [OW+1:0]   trial;
  logic [OW-1:0]   root_q;
  logic [CW-1:0]   cnt_q;
  logic            done_q;
  logic            ge;

  always_comb begin
    sh    = {rem_q[OW-1:0], rad_q[2*OW-1 -: 2]};
    trial = {root_q, 2'h1};
    ge    = sh >= trial;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rad_q  <= '0;
      rem_q  <= '0;
      root_q <= '0;
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rad_q  <= rad;
        rem_q  <= '0;
        root_q <= '0;
        cnt_q  <= CW'(OW);
      end else if (cnt_q != '0) begin
        rem_q  <= ge ? sh - trial : sh;
        root_q <= {root_q[OW-2:0], ge};
        rad_q  <= {rad_q[2*OW-3:0], 2'h0};
        cnt_q  <= cnt_q - CW'(1);
        done_q <= cnt_q == CW'(1);
      end
    end
  end

  assign done = done_q;
  assign root = root_q;
endmodule

// >>> core/cmp_pkg.sv
// Shared constants and command codes for the coordinated motion profiler
package cmp_pkg;
  localparam int CMP_AXES = 4;
  localparam int CMP_POS_W = 32;
  localparam int CMP_SPD_W = 24;
  localparam int CMP_SC_W = 4;
  localparam int CMP_QA_W = 9;
  localparam int CMP_SLOTS = 511;
  localparam int CMP_PLANES = 2;
  localparam int CMP_CLK_NS = 4;
  localparam int CMP_SAMPLE_NS = 1000000;
  localparam int CMP_SAMPLE_CYC = CMP_SAMPLE_NS / CMP_CLK_NS;

  typedef enum logic [4:0] {
    CMP_AXIS_GROUP_CHOOSE,
    CMP_PLANE_CHOOSE,
    CMP_ROUTE_PIECE,
    CMP_ROUTE_END_MARK,
    CMP_QUEUE_RUN,
    CMP_QUEUE_HALT,
    CMP_HARD_KILL,
    CMP_KILL_MOVING_ONLY,
    CMP_QUEUE_WIPE,
    CMP_GROUP_RATE,
    CMP_GROUP_RISE_RATE,
    CMP_GROUP_FALL_RATE,
    CMP_GROUP_S_CURVE,
    CMP_FOLLOW_ONOFF,
    CMP_HOLD_TILL_DONE,
    CMP_HOLD_TILL_ARRIVED,
    CMP_HOLD_TILL_FWD_COUNT,
    CMP_HOLD_TILL_REV_COUNT,
    CMP_HOLD_TILL_COORDINATE,
    CMP_TRIP_ON_ROUTE_RUN
  } cmp_cmd_t;
endpackage

// >>> core/cmp_profiler.sv
// Coordinated motion profiler: route queue, vector profile, trip points
//
// Functional notes
// - Follow mode: velocity zero crossing restarts move
// - Forward/reverse count holds, one axis each
// - Coordinate hold waits for absolute position
// - Path keeps vector speed, rise, fall rates
// - Axis group persists until chosen again
// - Two planes; commands use last chosen plane
// - Pieces are incremental from their start point
// - Queue holds 511 pieces, appends while moving
// - Wipe clears queue only while no sequence is active
// - Halt decelerates; kills stop instantly
// - End mark: decelerate to rest after last
// - Dry queue without end mark: instant stop
// - Free slots: 511 empty, zero full
// - Piece counter from zero, counts finished pieces
// - Vector length uses chosen axis group only
// - Group rate takes effect immediately
// - Piece start speed sets rate at piece start
// - Piece end speed met at piece end
// - Only one pending end speed tracked
// - Route run hold waits for path distance
// - S-curve constant smooths vector speed
`timescale 1ns/10ps
module cmp_profiler
  import cmp_pkg::*;
#(
  parameter int AXES       = CMP_AXES,
  parameter int PW         = CMP_POS_W,
  parameter int SW         = CMP_SPD_W,
  parameter int AW         = CMP_QA_W,
  parameter int SLOTS      = CMP_SLOTS,
  parameter int SAMPLE_CYC = CMP_SAMPLE_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire logic                     cmd_valid,
  input  wire cmp_cmd_t                 cmd_op,
  input  wire logic signed [PW-1:0]     cmd_arg,
  input  wire logic [$clog2(AXES)-1:0]  cmd_axis,
  input  wire logic [AXES*PW-1:0]       piece_inc,
  input  wire logic [SW-1:0]            piece_start_spd,
  input  wire logic [SW-1:0]            piece_end_spd,
  input  wire logic                     piece_has_start,
  input  wire logic                     piece_has_end,
  input  wire logic [AXES*PW-1:0]       axis_pos,
  output logic                          cmd_refused,
  output logic [AXES*PW-1:0]            axis_ref,
  output logic [SW-1:0]                 vec_speed,
  output logic                          seq_active,
  output logic [AW:0]                   free_slots,
  output logic [PW-1:0]                 piece_count,
  output logic [PW-1:0]                 route_run,
  output logic                          hold_busy,
  output logic                          hold_refused,
  output logic                          prog_killed,
  output logic [AXES-1:0]               move_restart,
  output logic                          plane_sel
);
  localparam int EW = 2 + 2*SW + AXES*PW;
  localparam int XW = $clog2(AXES);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LEN, ST_MOVE} cmp_state_t;

  cmp_state_t            st_q;
  logic [AW-1:0]         wr_ptr_q, rd_ptr_q;
  logic [AW:0]           count_q, free_q;
  logic [EW-1:0]         rd_data;
  logic                  push, pop, flush, wipe_ok, any_kill;
  logic [AXES-1:0]       grp_q [CMP_PLANES];
  logic [SW-1:0]         rate_q [CMP_PLANES];
  logic [SW-1:0]         rise_q [CMP_PLANES];
  logic [SW-1:0]         fall_q [CMP_PLANES];
  logic [CMP_SC_W-1:0]   sc_q [CMP_PLANES];
  logic                  plane_q, run_plane_q;
  logic [31:0]           tick_cnt_q;
  logic                  tick_q;
  logic signed [PW-1:0]  inc_q [AXES];
  logic signed [PW-1:0]  base_q [AXES];
  logic signed [PW-1:0]  ref_q [AXES];
  logic [PW-1:0]         len_q, done_q, end_left_q;
  logic [SW-1:0]         end_spd_q, v_cmd_q, v_out_q;
  logic                  has_end_q, end_pend_q, end_seen_q;
  logic                  halting_q, active_q;
  logic [PW-1:0]         piece_cnt_q, route_q;
  logic                  sq_done;
  logic [PW-1:0]         sq_root;
  cmp_cmd_t              hold_op_q;
  logic                  hold_busy_q, refused_q, killed_q, cmd_refused_q;
  logic [XW-1:0]         hold_axis_q;
  logic signed [PW-1:0]  hold_arg_q, hold_ref_q;
  logic [AXES-1:0]       follow_q, last_dir_q, moving_q, restart_q;
  logic signed [PW-1:0]  prev_pos_q [AXES];
  // Profile helpers
  logic [PW-1:0]         left_seg, step, adv;
  logic                  last_piece, e_on, brake, hold_met;
  logic [SW-1:0]         e_tgt, tgt, fall, rise, v_n, v_out_n;
  logic [PW-1:0]         e_left;
  logic [63:0]           v2, lim;
  logic signed [SW:0]    dv, sm;
  logic signed [PW:0]    hp, hd;

  function automatic logic is_cmd(input cmp_cmd_t op);
    return cmd_valid && cmd_op == op;
  endfunction

  function automatic logic [2*PW-1:0] sq_sum(input logic [AXES*PW-1:0] v,
                                              input logic [AXES-1:0] m);
    logic [2*PW-1:0]      s;
    logic signed [PW-1:0] a;
    logic [PW-1:0]        mag;
    s = '0;
    for (int i = 0; i < AXES; i++) begin
      a   = v[i*PW +: PW];
      mag = a[PW-1] ? PW'(-a) : PW'(a);
      if (m[i]) begin
        s = s + {{PW{1'b0}}, mag} * {{PW{1'b0}}, mag};
      end
    end
    return s;
  endfunction

  // Position along the piece; the divide is wide but only runs per sample
  function automatic logic signed [PW-1:0] frac(input logic signed [PW-1:0] a,
                                                input logic [PW-1:0] d,
                                                input logic [PW-1:0] l);
    logic signed [2*PW+1:0] p;
    p = '0;
    if (l != '0) begin
      p = (a * $signed({1'b0, d})) / $signed({1'b0, l});
    end
    return p[PW-1:0];
  endfunction

  assign wipe_ok  = is_cmd(CMP_QUEUE_WIPE) && !active_q;
  assign any_kill = is_cmd(CMP_HARD_KILL) || is_cmd(CMP_KILL_MOVING_ONLY);
  assign flush    = wipe_ok || any_kill || is_cmd(CMP_QUEUE_HALT);
  assign push = is_cmd(CMP_ROUTE_PIECE) && count_q < (AW+1)'(SLOTS)
              && !flush;
  assign pop  = st_q == ST_FETCH;

  cmp_queue_mem #(.WIDTH(EW), .AW(AW)) u_mem (
    .sys_clk (sys_clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_q),
    .wr_data ({piece_has_start, piece_has_end, piece_start_spd,
               piece_end_spd, piece_inc}),
    .rd_addr (rd_ptr_q),
    .rd_data (rd_data)
  );

  cmp_isqrt #(.OW(PW)) u_len (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (pop),
    .rad     (sq_sum(rd_data[AXES*PW-1:0], grp_q[run_plane_q])),
    .done    (sq_done),
    .root    (sq_root)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      count_q       <= '0;
      free_q        <= (AW+1)'(SLOTS);
      cmd_refused_q <= 1'b0;
    end else begin
      cmd_refused_q <= is_cmd(CMP_ROUTE_PIECE) && !push;
      free_q        <= (AW+1)'(SLOTS) - count_q;
      if (flush) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q  <= '0;
      end else begin
        wr_ptr_q <= wr_ptr_q + AW'(push);
        rd_ptr_q <= rd_ptr_q + AW'(pop);
        count_q  <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= tick_cnt_q == 32'(SAMPLE_CYC - 1);
      tick_cnt_q <= (tick_cnt_q == 32'(SAMPLE_CYC - 1)) ? '0
                    : tick_cnt_q + 32'h1;
    end
  end

  // Per-plane settings; the running plane is read live so changes bite now
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      plane_q <= 1'b0;
      for (int p = 0; p < CMP_PLANES; p++) begin
        grp_q[p]  <= '0;
        rate_q[p] <= '0;
        rise_q[p] <= '0;
        fall_q[p] <= '0;
        sc_q[p]   <= '0;
      end
    end else begin
      if (is_cmd(CMP_PLANE_CHOOSE)) plane_q <= cmd_arg[0];
      if (is_cmd(CMP_AXIS_GROUP_CHOOSE)) grp_q[plane_q] <= cmd_arg[AXES-1:0];
      if (is_cmd(CMP_GROUP_RATE)) rate_q[plane_q] <= cmd_arg[SW-1:0];
      if (is_cmd(CMP_GROUP_RISE_RATE)) rise_q[plane_q] <= cmd_arg[SW-1:0];
      if (is_cmd(CMP_GROUP_FALL_RATE)) fall_q[plane_q] <= cmd_arg[SW-1:0];
      if (is_cmd(CMP_GROUP_S_CURVE)) sc_q[plane_q] <= cmd_arg[CMP_SC_W-1:0];
      if (pop && rd_data[EW-1]) begin
        rate_q[run_plane_q] <= rd_data[EW-3 -: SW];
      end
    end
  end

  always_comb begin
    rise       = rise_q[run_plane_q];
    fall       = fall_q[run_plane_q];
    left_seg   = len_q - done_q;
    step       = (v_out_q == '0 && !halting_q) ? PW'(1) : PW'(v_out_q);
    adv        = step > left_seg ? left_seg : step;
    last_piece = count_q == '0 && end_seen_q;
    e_on       = last_piece || end_pend_q;
    e_tgt      = last_piece ? '0 : end_spd_q;
    e_left     = last_piece ? left_seg : end_left_q;
    tgt        = halting_q ? '0 : rate_q[run_plane_q];
    v2         = 64'(v_cmd_q) * 64'(v_cmd_q);
    lim        = 64'(e_tgt) * 64'(e_tgt) + 64'({fall, 1'b0}) * 64'(e_left);
    brake      = e_on && v_cmd_q > e_tgt && v2 > lim;
    if (brake) begin
      v_n = (v_cmd_q - e_tgt > fall) ? v_cmd_q - fall : e_tgt;
    end else if (v_cmd_q < tgt) begin
      v_n = (tgt - v_cmd_q > rise) ? v_cmd_q + rise : tgt;
    end else if (v_cmd_q > tgt) begin
      v_n = (v_cmd_q - tgt > fall) ? v_cmd_q - fall : tgt;
    end else begin
      v_n = v_cmd_q;
    end
    dv = $signed({1'b0, v_n}) - $signed({1'b0, v_out_q});
    sm = dv >>> sc_q[run_plane_q];
    if (sm == '0) sm = dv;
    v_out_n = SW'($signed({1'b0, v_out_q}) + sm);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q        <= ST_IDLE;
      active_q    <= 1'b0;
      halting_q   <= 1'b0;
      end_seen_q  <= 1'b0;
      end_pend_q  <= 1'b0;
      has_end_q   <= 1'b0;
      end_spd_q   <= '0;
      end_left_q  <= '0;
      run_plane_q <= 1'b0;
      len_q       <= '0;
      done_q      <= '0;
      v_cmd_q     <= '0;
      v_out_q     <= '0;
      piece_cnt_q <= '0;
      route_q     <= '0;
      for (int i = 0; i < AXES; i++) begin
        inc_q[i]  <= '0;
        base_q[i] <= '0;
        ref_q[i]  <= '0;
      end
    end else if (any_kill) begin
      st_q       <= ST_IDLE;
      active_q   <= 1'b0;
      halting_q  <= 1'b0;
      end_seen_q <= 1'b0;
      end_pend_q <= 1'b0;
      v_cmd_q    <= '0;
      v_out_q    <= '0;
      for (int i = 0; i < AXES; i++) base_q[i] <= ref_q[i];
    end else begin
      if (is_cmd(CMP_QUEUE_HALT) && active_q) halting_q <= 1'b1;
      case (st_q)
        ST_IDLE: begin
          if (is_cmd(CMP_QUEUE_RUN) && count_q != '0) begin
            st_q        <= ST_FETCH;
            active_q    <= 1'b1;
            run_plane_q <= plane_q;
            piece_cnt_q <= '0;
            route_q     <= '0;
            end_pend_q  <= 1'b0;
          end
        end
        ST_FETCH: begin
          for (int i = 0; i < AXES; i++) inc_q[i] <= rd_data[i*PW +: PW];
          has_end_q <= rd_data[EW-2];
          if (rd_data[EW-2]) begin
            end_spd_q  <= rd_data[EW-3-SW -: SW];
            end_pend_q <= 1'b1;
          end
          st_q <= ST_LEN;
        end
        ST_LEN: begin
          if (sq_done) begin
            len_q  <= sq_root;
            done_q <= '0;
            if (has_end_q) end_left_q <= sq_root;
            st_q   <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (tick_q) begin
            v_cmd_q    <= v_n;
            v_out_q    <= v_out_n;
            done_q     <= done_q + adv;
            route_q    <= route_q + adv;
            end_left_q <= end_left_q > adv ? end_left_q - adv : '0;
            for (int i = 0; i < AXES; i++) begin
              ref_q[i] <= base_q[i] + frac(inc_q[i], done_q + adv, len_q);
            end
            if (halting_q && v_out_q == '0 && v_cmd_q == '0) begin
              st_q       <= ST_IDLE;
              active_q   <= 1'b0;
              halting_q  <= 1'b0;
              end_seen_q <= 1'b0;
              for (int i = 0; i < AXES; i++) base_q[i] <= ref_q[i];
            end else if (adv == left_seg) begin
              for (int i = 0; i < AXES; i++) begin
                base_q[i] <= base_q[i] + inc_q[i];
                ref_q[i]  <= base_q[i] + inc_q[i];
              end
              piece_cnt_q <= piece_cnt_q + PW'(1);
              if (has_end_q) end_pend_q <= 1'b0;
              if (count_q != '0 && !halting_q) begin
                st_q <= ST_FETCH;
              end else begin
                // Dry queue without end mark halts with no ramp
                st_q       <= ST_IDLE;
                active_q   <= 1'b0;
                halting_q  <= 1'b0;
                end_seen_q <= 1'b0;
                v_cmd_q    <= '0;
                v_out_q    <= '0;
              end
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      if (is_cmd(CMP_ROUTE_END_MARK)) end_seen_q <= 1'b1;
    end
  end

  always_comb begin
    hp = $signed({axis_pos[hold_axis_q*PW + PW - 1],
                  axis_pos[hold_axis_q*PW +: PW]});
    hd = hp - $signed({hold_ref_q[PW-1], hold_ref_q});
    case (hold_op_q)
      CMP_HOLD_TILL_DONE:       hold_met = !active_q;
      CMP_HOLD_TILL_ARRIVED:    hold_met = !active_q
                                  && hp[PW-1:0] == ref_q[hold_axis_q];
      CMP_HOLD_TILL_FWD_COUNT:  hold_met = hd >= hold_arg_q;
      CMP_HOLD_TILL_REV_COUNT:  hold_met = -hd >= hold_arg_q;
      CMP_HOLD_TILL_COORDINATE: hold_met = (hold_arg_q >= hold_ref_q)
                                  ? hp >= hold_arg_q
                                  : hp <= hold_arg_q;
      CMP_TRIP_ON_ROUTE_RUN:    hold_met = $signed({1'b0, route_q})
                                  >= hold_arg_q;
      default:                  hold_met = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold_op_q   <= CMP_HOLD_TILL_DONE;
      hold_busy_q <= 1'b0;
      hold_axis_q <= '0;
      hold_arg_q  <= '0;
      hold_ref_q  <= '0;
      refused_q   <= 1'b0;
      killed_q    <= 1'b0;
    end else begin
      refused_q <= 1'b0;
      if (is_cmd(CMP_HARD_KILL)) begin
        killed_q    <= 1'b1;
        hold_busy_q <= 1'b0;
      end else if (cmd_valid && cmd_op >= CMP_HOLD_TILL_DONE) begin
        // Done and arrival make no sense once the target keeps moving
        if (cmd_op <= CMP_HOLD_TILL_ARRIVED && follow_q[cmd_axis]) begin
          refused_q <= 1'b1;
        end else begin
          hold_busy_q <= 1'b1;
          hold_op_q   <= cmd_op;
          hold_axis_q <= cmd_axis;
          hold_arg_q  <= cmd_arg;
          hold_ref_q  <= axis_pos[cmd_axis*PW +: PW];
        end
      end else if (hold_busy_q && hold_met) begin
        hold_busy_q <= 1'b0;
      end
      if (is_cmd(CMP_QUEUE_RUN)) killed_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      follow_q   <= '0;
      last_dir_q <= '0;
      moving_q   <= '0;
      restart_q  <= '0;
      for (int i = 0; i < AXES; i++) prev_pos_q[i] <= '0;
    end else begin
      restart_q <= '0;
      if (is_cmd(CMP_FOLLOW_ONOFF)) begin
        follow_q <= cmd_arg[AXES-1:0];
        moving_q <= '0;
      end
      if (tick_q) begin
        for (int i = 0; i < AXES; i++) begin
          prev_pos_q[i] <= axis_pos[i*PW +: PW];
          if (follow_q[i] && axis_pos[i*PW +: PW] != prev_pos_q[i]) begin
            last_dir_q[i] <= $signed(axis_pos[i*PW +: PW]) < prev_pos_q[i];
            moving_q[i]   <= 1'b1;
            restart_q[i]  <= moving_q[i] && last_dir_q[i]
                             != ($signed(axis_pos[i*PW +: PW])
                                 < prev_pos_q[i]);
          end
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < AXES; i++) axis_ref[i*PW +: PW] = ref_q[i];
  end

  assign cmd_refused  = cmd_refused_q;
  assign vec_speed    = v_out_q;
  assign seq_active   = active_q;
  assign free_slots   = free_q;
  assign piece_count  = piece_cnt_q;
  assign route_run    = route_q;
  assign hold_busy    = hold_busy_q;
  assign hold_refused = refused_q;
  assign prog_killed  = killed_q;
  assign move_restart = restart_q;
  assign plane_sel    = plane_q;
endmodule

// >>> core/cmp_queue_mem.sv
// Route piece queue storage with registered read data
`timescale 1ns/10ps
module cmp_queue_mem #(
  parameter int WIDTH = 8,
  parameter int AW    = 9
) (
  input  wire logic             sys_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [1<<AW];
  logic [WIDTH-1:0] rd_data_q;

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data_q <= mem[rd_addr];
  end

  assign rd_data = rd_data_q;
endmodule

// >>> testbench/cmp_host_model.sv
// Host model: issues commands, ideal servo closes the position loop
`timescale 1ns/10ps
module cmp_host_model
  import cmp_pkg::*;
(
  input  wire logic [CMP_AXES*CMP_POS_W-1:0] axis_ref,
  input  wire logic                          sys_clk,
  output logic                               cmd_valid,
  output cmp_cmd_t                           cmd_op,
  output logic signed [CMP_POS_W-1:0]        cmd_arg,
  output logic [1:0]                         cmd_axis,
  output logic [CMP_AXES*CMP_POS_W-1:0]      piece_inc,
  output logic [CMP_AXES*CMP_POS_W-1:0]      axis_pos
);
  // Ideal servo: position equals reference
  assign axis_pos = axis_ref;
  initial begin
    cmd_valid = 1'h0;
    cmd_op = CMP_QUEUE_HALT;
    cmd_arg = 32'h0;
    cmd_axis = 2'h0;
    piece_inc = '0;
  end
  // No done/arrived holds while following
  task automatic send(input cmp_cmd_t op, input logic [31:0] arg = 32'h0,
                      input logic [1:0] ax = 2'h0);
    @(negedge sys_clk);
    cmd_valid = 1'h1;
    cmd_op = op;
    cmd_arg = arg;
    cmd_axis = ax;
  endtask
  task automatic piece(input logic [31:0] a0, input logic [31:0] a1);
    send(CMP_ROUTE_PIECE);
    piece_inc = {64'h0, a1, a0};
  endtask
  // Junk on released fields exposes stale sampling
  task automatic idle();
    @(negedge sys_clk);
    cmd_valid = 1'h0;
    cmd_arg = ~cmd_arg;
    piece_inc = ~piece_inc;
  endtask
endmodule

// >>> testbench/cmp_profiler_props.sv
// Port checker for the coordinated motion profiler
`timescale 1ns/10ps
module cmp_profiler_props
  import cmp_pkg::*;
#(
  parameter int AXES  = CMP_AXES,
  parameter int PW    = CMP_POS_W,
  parameter int SW    = CMP_SPD_W,
  parameter int AW    = CMP_QA_W,
  parameter int SLOTS = CMP_SLOTS
) (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 cmd_valid,
  input wire cmp_cmd_t             cmd_op,
  input wire logic signed [PW-1:0] cmd_arg,
  input wire logic                 cmd_refused,
  input wire logic [AXES*PW-1:0]   axis_ref,
  input wire logic [SW-1:0]        vec_speed,
  input wire logic                 seq_active,
  input wire logic [AW:0]          free_slots,
  input wire logic [PW-1:0]        piece_count,
  input wire logic [PW-1:0]        route_run,
  input wire logic                 hold_busy,
  input wire logic                 prog_killed,
  input wire logic [AXES-1:0]      move_restart,
  input wire logic                 plane_sel
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_refuse_cause: assert property (cmd_refused |->
    $past(cmd_valid) && $past(cmd_op) == CMP_ROUTE_PIECE)
    else $error("refusal without a piece request");
  a_free_bound: assert property (free_slots <= SLOTS)
    else $error("free slot count above queue size");
  a_kill_stop: assert property (cmd_valid && cmd_op == CMP_HARD_KILL |=>
    !seq_active && vec_speed == '0 && prog_killed)
    else $error("hard kill did not stop at once");
  a_kill1_stop: assert property (
    cmd_valid && cmd_op == CMP_KILL_MOVING_ONLY |=>
    !seq_active && vec_speed == '0)
    else $error("motion kill did not stop at once");
  a_run_zeroes: assert property ($rose(seq_active) |->
    piece_count == '0 && route_run == '0)
    else $error("counters not zero at run");
  a_plane_take: assert property (
    cmd_valid && cmd_op == CMP_PLANE_CHOOSE |=>
    plane_sel == $past(cmd_arg[0]))
    else $error("plane choice not taken");
  a_wipe_empties: assert property (
    (cmd_valid && cmd_op == CMP_QUEUE_WIPE && !seq_active) ##1 !cmd_valid
    |-> ##1 free_slots == SLOTS)
    else $error("wipe left pieces queued");
  a_hold_starts: assert property (
    cmd_valid && cmd_op == CMP_HOLD_TILL_COORDINATE |=> hold_busy)
    else $error("coordinate hold not pending");
  a_idle_frozen: assert property (
    !seq_active && !$past(seq_active) && !$past(seq_active, 2)
    |-> $stable(axis_ref))
    else $error("reference moved while idle");
  a_restart_pulse: assert property (|move_restart |=> move_restart == '0)
    else $error("restart pulse longer than a cycle");
endmodule
bind cmp_profiler cmp_profiler_props #(
  .AXES(AXES), .PW(PW), .SW(SW), .AW(AW), .SLOTS(SLOTS)
) u_props (.*);

// >>> testbench/cmp_profiler_tb.sv
// Self-checking bench for the coordinated motion profiler
`timescale 1ns/10ps
module cmp_profiler_tb;
  import cmp_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic cmd_valid, cmd_refused, seq_active, hold_busy, prog_killed;
  logic plane_sel, hold_refused;
  cmp_cmd_t cmd_op;
  logic signed [31:0] cmd_arg;
  logic [1:0] cmd_axis;
  logic [127:0] piece_inc, axis_pos, axis_ref;
  logic [23:0] vec_speed;
  logic [9:0] free_slots;
  logic [31:0] piece_count, route_run, p0;
  logic [3:0] move_restart;
  int num_errors = 0;
  int comparisons = 0;
  bit restarted = 1'b0;
  always #2 sys_clk = ~sys_clk;
  // Short sample period, brief run
  cmp_profiler #(.SAMPLE_CYC(8)) u_dut (
    .*, .piece_start_spd(24'h0), .piece_end_spd(24'h0),
    .piece_has_start(1'h0), .piece_has_end(1'h0));
  cmp_host_model u_host (.*);
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Bounded wait for hold or sequence to drop
  task automatic wait_drop(input bit hold);
    for (int i = 0; i < 8000; i++) begin
      @(negedge sys_clk);
      restarted |= |move_restart;
      if ((hold ? hold_busy : seq_active) === 1'h0)
        return;
    end
    num_errors++;
    $display("BAD wait_drop expected 0 seen 1");
    close_out();
  endtask
  task automatic t_reset();
    @(negedge sys_clk);
    chk("free_slots", 32'h1ff, 32'(free_slots));
    chk("piece_count", 32'h0, piece_count);
    chk("seq_active", 32'h0, 32'(seq_active));
    $display("test reset done");
  endtask
  task automatic t_plane();
    u_host.send(CMP_PLANE_CHOOSE, 32'h1);
    u_host.idle();
    chk("plane_sel", 32'h1, 32'(plane_sel));
    u_host.send(CMP_PLANE_CHOOSE);
    u_host.idle();
    chk("plane_sel", 32'h0, 32'(plane_sel));
    $display("test plane done");
  endtask
  task automatic t_route();
    u_host.send(CMP_AXIS_GROUP_CHOOSE, 32'h3);
    u_host.send(CMP_GROUP_RATE, 32'h4);
    u_host.send(CMP_GROUP_RISE_RATE, 32'h2);
    u_host.send(CMP_GROUP_FALL_RATE, 32'h2);
    u_host.send(CMP_GROUP_S_CURVE);
    u_host.piece(32'h14, 32'h0);
    u_host.piece(32'h0, 32'h14);
    u_host.send(CMP_ROUTE_END_MARK);
    u_host.send(CMP_QUEUE_RUN);
    u_host.idle();
    chk("seq_active", 32'h1, 32'(seq_active));
    chk("piece_count", 32'h0, piece_count);
    u_host.send(CMP_HOLD_TILL_COORDINATE, 32'ha);
    u_host.idle();
    chk("hold_busy", 32'h1, 32'(hold_busy));
    wait_drop(1'b1);
    wait_drop(1'b0);
    chk("axis0", 32'h14, axis_ref[31:0]);
    chk("axis1", 32'h14, axis_ref[63:32]);
    chk("route_run", 32'h28, route_run);
    chk("vec_speed", 32'h0, 32'(vec_speed));
    // Group not chosen again: it persists
    u_host.piece(32'hfffffff8, 32'h0);
    u_host.send(CMP_ROUTE_END_MARK);
    u_host.send(CMP_QUEUE_RUN);
    u_host.idle();
    wait_drop(1'b0);
    chk("axis0", 32'hc, axis_ref[31:0]);
    $display("test route done");
  endtask
  task automatic t_kill();
    u_host.piece(32'h190, 32'h0);
    u_host.piece(32'h190, 32'h0);
    u_host.send(CMP_ROUTE_END_MARK);
    u_host.send(CMP_QUEUE_RUN);
    u_host.idle();
    repeat (40) @(negedge sys_clk);
    u_host.send(CMP_HARD_KILL);
    u_host.idle();
    chk("seq_active", 32'h0, 32'(seq_active));
    chk("vec_speed", 32'h0, 32'(vec_speed));
    chk("prog_killed", 32'h1, 32'(prog_killed));
    u_host.piece(32'h190, 32'h0);
    u_host.send(CMP_QUEUE_RUN);
    u_host.idle();
    repeat (40) @(negedge sys_clk);
    chk("seq_active", 32'h1, 32'(seq_active));
    u_host.send(CMP_KILL_MOVING_ONLY, 32'h1);
    u_host.idle();
    chk("seq_active", 32'h0, 32'(seq_active));
    chk("prog_killed", 32'h0, 32'(prog_killed));
    $display("test kill done");
  endtask
  task automatic t_dry();
    p0 = axis_ref[31:0];
    u_host.send(CMP_FOLLOW_ONOFF, 32'h1);
    u_host.piece(32'h10, 32'h0);
    u_host.piece(32'hfffffff8, 32'h0);
    u_host.send(CMP_QUEUE_RUN);
    u_host.send(CMP_HOLD_TILL_FWD_COUNT, 32'h10);
    u_host.idle();
    chk("hold_refused", 32'h0, 32'(hold_refused));
    wait_drop(1'b1);
    wait_drop(1'b0);
    chk("move_restart", 32'h1, 32'(restarted));
    chk("axis0", p0 + 32'h8, axis_ref[31:0]);
    chk("vec_speed", 32'h0, 32'(vec_speed));
    $display("test dry done");
  endtask
  task automatic t_full();
    for (int i = 0; i < 512; i++)
      u_host.piece(32'h1, 32'h0);
    u_host.idle();
    chk("cmd_refused", 32'h1, 32'(cmd_refused));
    repeat (2) @(negedge sys_clk);
    chk("free_slots", 32'h0, 32'(free_slots));
    u_host.send(CMP_QUEUE_WIPE);
    u_host.idle();
    repeat (2) @(negedge sys_clk);
    chk("free_slots", 32'h1ff, 32'(free_slots));
    $display("test full done");
  endtask
  initial begin
    repeat (6) @(negedge sys_clk);
    rst = 1'h0;
    t_reset();
    t_plane();
    t_route();
    t_kill();
    t_dry();
    t_full();
    close_out();
  end
endmodule
